/* File: program_sequencer.sv */
// Program counter, return stack, skip flag, data pointer, ROM and RAM.
// Assumes an APB master on pclk; every command is one CMD register write.
`timescale 1ns/1ps
`default_nettype none

module program_sequencer
  import seq_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic backup_return,
  output logic [ROM_W-1:0] fetch_word,
  output logic [3:0] port_d
);

  // ******************************************************************
  // Storage
  // ******************************************************************
  logic [PC_W-1:0] pc;
  logic [DEPTH_W-1:0] stack_depth_pointer;
  logic [PC_W-1:0] stack [STACK_DEPTH];
  logic skip;
  logic saved_skip;
  logic skipped;
  logic [7:0] table_data;
  ptr_t ptr;
  logic [3:0] ram [RAM_WORDS];
  logic [ROM_W-1:0] rom [ROM_WORDS];

  // ******************************************************************
  // Decoding helpers
  // ******************************************************************
  // Small variant ignores the top page bit
  function automatic logic [11:0] rom_index(input logic [PC_W-1:0] a);
    rom_index = {a[11] & LARGE_VARIANT, a[10:0]};
  endfunction : rom_index

  // Small variant ignores the top file bit
  function automatic logic [7:0] ram_index(input ptr_t p);
    ram_index = {p.x[3] & LARGE_VARIANT, p.x[2:0], p.y};
  endfunction : ram_index

  // Fixed priority among the four requests
  function automatic logic [OFF_W-1:0] vector_of(input logic [3:0] r);
    if (r[0]) begin
      vector_of = VEC_EXT;
    end else if (r[1]) begin
      vector_of = VEC_TIMER1;
    end else if (r[2]) begin
      vector_of = VEC_TIMER2;
    end else begin
      vector_of = VEC_CONV;
    end
  endfunction : vector_of

  // ******************************************************************
  // APB decode
  // ******************************************************************
  wire cmd_t cmd = cmd_t'(pwdata[15:0]);
  wire wr_access = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire mapped = (paddr == CMD_OFS) || (paddr == PC_OFS) ||
    (paddr == STATUS_OFS) || (paddr == TABLE_OFS) ||
    (paddr == POINTER_OFS) || (paddr == RAM_DATA_OFS) ||
    (paddr == PORT_OFS) || (paddr == ROM_LOAD_OFS);
  wire fire = wr_access & (paddr == CMD_OFS);
  wire ptr_wr = wr_access & (paddr == POINTER_OFS);
  wire ram_wr = wr_access & (paddr == RAM_DATA_OFS);
  wire rom_wr = wr_access & (paddr == ROM_LOAD_OFS);

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ******************************************************************
  // Command qualification
  // ******************************************************************
  // A pending skip swallows the next command, but an interrupt still
  // enters and carries the pending skip along with it.
  wire is_int_op = (cmd.op == OP_INTERRUPT);
  wire execute = fire & (~skip | is_int_op);
  wire skip_now = fire & skip & ~is_int_op;
  wire do_step = execute & (cmd.op == OP_STEP);
  wire do_branch = execute & (cmd.op == OP_BRANCH);
  wire do_call = execute & (cmd.op == OP_CALL);
  wire do_page2 = execute & (cmd.op == OP_PAGE2_CALL);
  wire do_ret = execute & (cmd.op == OP_RETURN);
  wire do_reti = execute & (cmd.op == OP_RETURN_INT);
  wire do_int = execute & is_int_op & (|cmd.arg[3:0]);
  wire do_table = execute & (cmd.op == OP_TABLE_READ);
  wire do_skipset = execute & (cmd.op == OP_SKIP_SET);
  wire do_rbset = execute & (cmd.op == OP_RAM_BIT_SET);
  wire do_rbclr = execute & (cmd.op == OP_RAM_BIT_CLEAR);
  wire do_rbtest = execute & (cmd.op == OP_RAM_BIT_TEST_SKIP);
  wire do_pset = execute & (cmd.op == OP_PORT_BIT_SET);
  wire do_pclr = execute & (cmd.op == OP_PORT_BIT_CLEAR);
  wire do_ptest = execute & (cmd.op == OP_PORT_BIT_TEST_SKIP);

  // ******************************************************************
  // Program counter and stack addressing
  // ******************************************************************
  wire [7:0] ram_addr = ram_index(ptr);
  wire [3:0] ram_word = ram[ram_addr];
  wire [1:0] bit_sel = cmd.arg[1:0];
  wire [1:0] port_sel = ptr.y[1:0];
  wire port_valid = (ptr.y[3:2] == 2'b00);
  wire [PC_W-1:0] pc_inc = pc + 12'h001;
  wire [PC_W-1:0] step_len = cmd.arg[0] ? 12'h002 : 12'h001;
  wire push = do_call | do_page2 | do_int;
  wire [DEPTH_W-1:0] depth_up = stack_depth_pointer + 3'h1;
  wire [DEPTH_W-1:0] depth_down = stack_depth_pointer - 3'h1;
  wire [PC_W-1:0] top = stack[stack_depth_pointer];
  wire [PC_W-1:0] table_addr = {cmd.arg[11:7], cmd.arg[6:0]};
  wire [7:0] table_byte = rom[rom_index(table_addr)][7:0];
  logic [PC_W-1:0] next_pc;

  // Target selection; carry out of the offset walks into the page
  always_comb begin
    next_pc = pc;
    if (skip_now) begin
      next_pc = pc_inc;
    end else if (do_step) begin
      next_pc = pc + step_len;
    end else if (do_branch | do_call) begin
      next_pc = cmd.arg;
    end else if (do_page2) begin
      next_pc = {CALL_PAGE, cmd.arg[6:0]};
    end else if (do_ret | do_reti) begin
      next_pc = top;
    end else if (do_int) begin
      next_pc = {VECTOR_PAGE, vector_of(cmd.arg[3:0])};
    end else if (do_table | do_skipset | do_rbset | do_rbclr |
                 do_rbtest | do_pset | do_pclr | do_ptest) begin
      next_pc = pc_inc;
    end
  end

  // Table read is a push and a pop in one step, so the pointer stays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= PC_RESET;
      stack_depth_pointer <= DEPTH_RESET;
    end else if (backup_return) begin
      pc <= PC_RESET;
      stack_depth_pointer <= DEPTH_RESET;
    end else begin
      pc <= next_pc;
      if (push) begin
        stack_depth_pointer <= depth_up;
      end else if (do_ret | do_reti) begin
        stack_depth_pointer <= depth_down;
      end
    end
  end

  // Return addresses; no reset, contents are only read after a push
  always_ff @(posedge pclk) begin
    if (do_int) begin
      stack[depth_up] <= pc;
    end else if (push | do_table) begin
      stack[depth_up] <= pc_inc;
    end
  end

  // ******************************************************************
  // Skip flag and its interrupt save copy
  // ******************************************************************
  logic next_skip;
  always_comb begin
    next_skip = skip;
    if (skip_now || do_int) begin
      next_skip = 1'b0;
    end else if (do_reti) begin
      next_skip = saved_skip;
    end else if (do_skipset) begin
      next_skip = cmd.arg[0];
    end else if (do_rbtest) begin
      next_skip = ~ram_word[bit_sel];
    end else if (do_ptest) begin
      next_skip = port_valid & ~port_d[port_sel];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip <= 1'b0;
      saved_skip <= 1'b0;
      skipped <= 1'b0;
    end else begin
      skip <= next_skip;
      skipped <= skip_now | (skipped & ~execute);
      if (do_int) begin
        saved_skip <= skip;
      end
    end
  end

  // ******************************************************************
  // Data pointer, port D and table data
  // ******************************************************************
  // The pointer resets to zero even though software must load it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr <= '0;
      port_d <= 4'h0;
      table_data <= 8'h00;
      fetch_word <= '0;
    end else begin
      if (ptr_wr) begin
        ptr <= ptr_t'(pwdata[8:0]);
      end
      if ((do_pset | do_pclr) && port_valid) begin
        port_d[port_sel] <= do_pset;
      end
      if (do_table) begin
        table_data <= table_byte;
      end
      fetch_word <= rom[rom_index(pc)];
    end
  end

  // ******************************************************************
  // RAM and ROM arrays
  // ******************************************************************
  // Bit operations write only the selected bit of the nibble in one cycle
  always_ff @(posedge pclk) begin
    if (ram_wr) begin
      ram[ram_addr] <= pwdata[3:0];
    end else if (do_rbset | do_rbclr) begin
      ram[ram_addr][bit_sel] <= do_rbset;
    end
    if (rom_wr) begin
      rom[rom_index(pwdata[11:0])] <= pwdata[25:16];
    end
  end

  // ******************************************************************
  // Read data, captured in the setup phase
  // ******************************************************************
  logic [31:0] next_prdata;
  always_comb begin
    case (paddr)
      PC_OFS: next_prdata = {20'h00000, pc};
      STATUS_OFS: next_prdata = {26'h0000000, skipped, saved_skip, skip,
                                 stack_depth_pointer};
      TABLE_OFS: next_prdata = {24'h000000, table_data};
      POINTER_OFS: next_prdata = {23'h000000, ptr};
      RAM_DATA_OFS: next_prdata = {28'h0000000, ram_word};
      PORT_OFS: next_prdata = {28'h0000000, port_d};
      default: next_prdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  // Return point of the latest call; commands arrive cycles apart, so
  // the matching return is found by marking rather than by a delay.
  logic [PC_W-1:0] call_mark;
  logic [DEPTH_W-1:0] depth_mark;
  logic mark_valid;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_mark <= PC_RESET;
      depth_mark <= DEPTH_RESET;
      mark_valid <= 1'b0;
    end else if (backup_return) begin
      mark_valid <= 1'b0;
    end else if (do_call | do_page2) begin
      call_mark <= pc + 12'h001;
      depth_mark <= stack_depth_pointer;
      mark_valid <= 1'b1;
    end else if (do_ret | do_reti | do_int) begin
      mark_valid <= 1'b0;
    end
  end

  first_push_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    push && stack_depth_pointer == DEPTH_RESET && !backup_return
    |=> stack_depth_pointer == 3'h0)
    else $error("push from reset pointer did not reach entry zero");

  push_pop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    do_ret && mark_valid && !backup_return
    |=> stack_depth_pointer == depth_mark && pc == call_mark)
    else $error("return did not restore pointer and pc of the call");

  page_roll_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    do_step && !cmd.arg[0] && pc[6:0] == 7'h7f && !backup_return
    |=> pc[6:0] == 7'h00 && pc[11:7] == $past(pc[11:7]) + 5'h01)
    else $error("offset 127 did not roll into next page");

  vector_pick_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    do_int && cmd.arg[1] && !cmd.arg[0] && !backup_return
    |=> pc == {VECTOR_PAGE, VEC_TIMER1})
    else $error("timer 1 vector not taken");

  skip_save_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    do_int |=> !skip && saved_skip == $past(skip))
    else $error("skip flag not saved on interrupt entry");

  skip_swallow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fire && skip && cmd.op == OP_BRANCH && !backup_return
    |=> pc == $past(pc_inc) && !skip)
    else $error("skipped branch was executed");

  page2_entry_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    do_page2 && !backup_return |=> pc[11:7] == CALL_PAGE)
    else $error("one-word call did not land on page 2");

  table_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    do_table && !backup_return
    |=> stack_depth_pointer == $past(stack_depth_pointer) &&
        pc == $past(pc) + 12'h001 && table_data == $past(table_byte))
    else $error("table read disturbed stack or returned wrong byte");

  bit_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    do_rbset |=> ram[$past(ram_addr)][$past(bit_sel)] == 1'b1)
    else $error("RAM bit set did not take");

  backup_restart_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    backup_return |=> pc == PC_RESET && stack_depth_pointer == DEPTH_RESET)
    else $error("return from back-up did not restart pc and pointer");

endmodule : program_sequencer

`default_nettype wire

/* File: program_sequencer_bench.sv */
// Self-checking bench: integer model of pc, stack, skip, RAM and port.
// Assumes the sequencer takes one command per CMD register write.
`timescale 1ns/1ps
`default_nettype none

module program_sequencer_bench;
  import seq_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic backup_return = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] fetch_word;
  logic [3:0] port_d;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 58060;
  int pc = 0, depth = 7, skip = 0, saved = 0, sw = 0, tbl = 0, port = 0;
  int ptr = 0, y = 0, a, w, b;
  int stk[8];
  int ram[256];
  int rom[int];

  program_sequencer #(.LARGE_VARIANT(1'b1)) u_program_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .backup_return(backup_return),
    .fetch_word(fetch_word), .port_d(port_d));

  seq_master u_seq_master (
    .pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // ******************************************************************
  // Checking and bus helpers
  // ******************************************************************
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] adr, input int d);
    u_seq_master.xfer(1'b1, adr, 32'(d), rd, err);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] adr,
      input int exp);
    u_seq_master.xfer(1'b0, adr, 32'h0, rd, err);
    check(what, rd, 32'(exp));
  endtask : rdchk

  // Model first, then the write; a swallowed command still moves pc
  task automatic cmd(input int op, input int arg);
    int st;
    if (skip != 0 && op != 7) begin
      pc = pc + 1;
      skip = 0;
      sw = 1;
    end else begin
      sw = 0;
      b = (ram[ptr] >> (arg % 4)) & 1;
      case (op)
        1: pc = pc + 1 + (arg & 1);
        2: pc = arg;
        3, 4: begin
          depth = (depth + 1) % 8;
          stk[depth] = (pc + 1) % 4096;
          pc = (op == 3) ? arg : 256 + arg % 128;
        end
        5, 6: begin
          pc = stk[depth];
          depth = (depth + 7) % 8;
          if (op == 6) skip = saved;
        end
        7: begin
          depth = (depth + 1) % 8;
          stk[depth] = pc;
          saved = skip;
          skip = 0;
          pc = (arg & 1) ? 128 : (arg & 2) ? 132 : (arg & 4) ? 134 : 140;
        end
        default: begin
          pc = pc + 1;
          if (op == 8) tbl = rom[arg] & 255;
          if (op == 9) skip = arg & 1;
          if (op == 10) ram[ptr] = ram[ptr] | (1 << (arg % 4));
          if (op == 11) ram[ptr] = ram[ptr] & ~(1 << (arg % 4));
          if (op == 12) skip = (b == 0);
          if (op == 13 && y < 4) port = port | (1 << y);
          if (op == 14 && y < 4) port = port & ~(1 << y);
          if (op == 15) skip = (y < 4) && ((port >> y) & 1) == 0;
        end
      endcase
    end
    pc = pc % 4096;
    wr(CMD_OFS, (arg << 4) | op);
    rdchk("pc", PC_OFS, pc);
    st = depth | skip << 3 | saved << 4 | sw << 5;
    rdchk("status", STATUS_OFS, st);
  endtask : cmd

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    wrap_up();
  end

  // ******************************************************************
  // Tests
  // ******************************************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("reset status", STATUS_OFS, 7);
    u_seq_master.xfer(1'b0, 8'h40, 32'h0, rd, err);
    check("unmapped error", {31'h0, err}, 32'h1);
    $display("test reset finished");
    // First page-2 call lands in entry zero; routine runs past page 2
    cmd(4, 127);
    cmd(1, 0);
    cmd(5, 0);
    for (int i = 0; i < 9; i++) cmd(3, $random(seed) & 4095);
    for (int i = 0; i < 9; i++) cmd(5, 0);
    cmd(2, 127);
    cmd(1, 0);
    cmd(1, 1);
    $display("test stack finished");
    // Each request source as the highest priority one pending, with skip pending or not
    for (int i = 0; i < 4; i++) begin
      cmd(9, i % 2);
      cmd(7, (1 << i) | (($random(seed) & 7) << (i + 1) & 15));
      cmd(6, 0);
      cmd(2, 512);
    end
    $display("test interrupt finished");
    for (int i = 0; i < 4; i++) begin
      a = $random(seed) & 4095;
      w = $random(seed) & 1023;
      wr(ROM_LOAD_OFS, (w << 16) | a);
      rom[a] = w;
      cmd(8, a);
      rdchk("table", TABLE_OFS, tbl);
      cmd(2, a);
      check("fetch", {22'h0, fetch_word}, 32'(w));
    end
    $display("test rom finished");
    // Pointer always loaded before any RAM use
    for (int i = 0; i < 6; i++) begin
      a = $random(seed) & 511;
      wr(POINTER_OFS, a);
      rdchk("pointer", POINTER_OFS, a);
      ptr = a & 255;
      y = a & 15;
      ram[ptr] = $random(seed) & 15;
      wr(RAM_DATA_OFS, ram[ptr]);
      cmd(10, $random(seed) & 3);
      cmd(11, $random(seed) & 3);
      cmd(12, $random(seed) & 3);
      cmd(1, 0);
      rdchk("ram", RAM_DATA_OFS, ram[ptr]);
      cmd(13 + i % 2, 0);
      cmd(15, 0);
      cmd(1, 0);
      rdchk("port", PORT_OFS, port);
      check("port pins", {28'h0, port_d}, 32'(port));
    end
    $display("test ram finished");
    cmd(3, 300);
    backup_return <= 1'b1;
    @(posedge pclk);
    backup_return <= 1'b0;
    @(posedge pclk);
    pc = 0;
    depth = 7;
    cmd(4, 9);
    cmd(5, 0);
    $display("test backup finished");
    wrap_up();
  end
endmodule : program_sequencer_bench
`default_nettype wire

/* File: seq_master.sv */
// APB master standing in for the instruction decoder side.
// Assumes a free running pclk and a slave that answers with pready.
`timescale 1ns/1ps
`default_nettype none

module seq_master (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ******************************************************************
  // One transfer
  // ******************************************************************
  // Entered just after a rising edge; an idle edge follows the release
  // so psel is never driven twice in one time step.
  task automatic xfer(input logic wr, input logic [7:0] addr,
      input logic [31:0] data, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
endmodule : seq_master
`default_nettype wire

/* File: seq_pkg.sv */
// Constants, command layout and pointer layout for the program sequencer.
// Assumes one 100 MHz clock and an APB master issuing 32-bit transfers.
//
// Behaviour
// - Skip flag suppresses the following instruction
// - Interrupt entry saves skip flag, restored on return
// - After reset first call stores into entry zero
// - Eight stack entries, 3-bit pointer, overflow overwrites
// - Program counter advances by instruction length
// - Branches, calls, returns load target address
// - Page field bits 11..7, offset bits 6..0
// - Offset 127 rolls into next page
// - Data pointer holds group, file and digit
// - Digit field also selects port D bit
// - Software loads pointer before RAM use
// - ROM words 10 bits, pages of 128
// - ROM 2048 or 4096 words by variant
// - Page 1 holds interrupt vectors, loaded on entry
// - Vectors 0,4,6,C with fixed priority
// - One-word call lands on page 2
// - Page 2 routines may run past page 2
// - Table read returns low ROM byte
// - RAM nibbles with single-bit set, clear, test
// - RAM 128 or 256 nibbles by variant
package seq_pkg;

  // ******************************************************************
  // Sizes
  // ******************************************************************
  localparam int PC_W = 12;
  localparam int OFF_W = 7;
  localparam int PAGE_W = 5;
  localparam int ROM_W = 10;
  localparam int ROM_WORDS = 4096;
  localparam int RAM_WORDS = 256;
  localparam int STACK_DEPTH = 8;
  localparam int DEPTH_W = 3;

  // ******************************************************************
  // Register offsets (byte addresses)
  // ******************************************************************
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] PC_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] TABLE_OFS = 8'h0c;
  localparam logic [7:0] POINTER_OFS = 8'h10;
  localparam logic [7:0] RAM_DATA_OFS = 8'h14;
  localparam logic [7:0] PORT_OFS = 8'h18;
  localparam logic [7:0] ROM_LOAD_OFS = 8'h1c;

  // ******************************************************************
  // Reset values and fixed addresses
  // ******************************************************************
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [DEPTH_W-1:0] DEPTH_RESET = 3'h7;
  localparam logic [PAGE_W-1:0] VECTOR_PAGE = 5'h01;
  localparam logic [PAGE_W-1:0] CALL_PAGE = 5'h02;
  localparam logic [OFF_W-1:0] VEC_EXT = 7'h00;
  localparam logic [OFF_W-1:0] VEC_TIMER1 = 7'h04;
  localparam logic [OFF_W-1:0] VEC_TIMER2 = 7'h06;
  localparam logic [OFF_W-1:0] VEC_CONV = 7'h0c;

  // ******************************************************************
  // Commands from the instruction decoder side
  // ******************************************************************
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_STEP = 4'h1, OP_BRANCH = 4'h2, OP_CALL = 4'h3,
    OP_PAGE2_CALL = 4'h4, OP_RETURN = 4'h5, OP_RETURN_INT = 4'h6,
    OP_INTERRUPT = 4'h7, OP_TABLE_READ = 4'h8, OP_SKIP_SET = 4'h9,
    OP_RAM_BIT_SET = 4'ha, OP_RAM_BIT_CLEAR = 4'hb,
    OP_RAM_BIT_TEST_SKIP = 4'hc, OP_PORT_BIT_SET = 4'hd,
    OP_PORT_BIT_CLEAR = 4'he, OP_PORT_BIT_TEST_SKIP = 4'hf
  } op_t;

  typedef struct packed {
    logic [11:0] arg;
    op_t op;
  } cmd_t;

  // RAM address pointer: group, file, digit
  typedef struct packed {
    logic z;
    logic [3:0] x;
    logic [3:0] y;
  } ptr_t;

endpackage : seq_pkg
